/* hdl/smpm_pkg.sv */
// constants, types and register map of the sleep mode power manager
// assumes a 200 MHz system clock and a classic wishbone register bus
package smpm_pkg;
  // clock rate and fixed times
  localparam int CLK_MHZ           = 200;
  localparam int BOD_WAKE_US       = 60;
  localparam int BOD_WAKE_CYC_DFLT = BOD_WAKE_US * CLK_MHZ;

  typedef logic [15:0] smpm_cnt_t;
  localparam smpm_cnt_t CNT_ONE           = 16'h0001;
  localparam smpm_cnt_t HALT_CYC          = 16'h0004;
  localparam smpm_cnt_t STBY_CYC          = 16'h0006;
  localparam smpm_cnt_t RESTART_BASE_DFLT = 16'h0400;

  // brown-out sleep-off timed sequence
  typedef logic [2:0] smpm_seq_t;
  localparam smpm_seq_t SEQ_ZERO      = 3'h0;
  localparam smpm_seq_t SEQ_ONE       = 3'h1;
  localparam smpm_seq_t UNLOCK_CYC    = 3'h4;
  localparam smpm_seq_t BROWNOUT_SLEEP_OFF_TOTAL    = 3'h6;
  localparam smpm_seq_t BROWNOUT_SLEEP_OFF_ACT_LAST = 3'h3;

  // sleep select codes
  localparam logic [2:0] MODE_IDLE  = 3'h0;
  localparam logic [2:0] MODE_ADCNR = 3'h1;
  localparam logic [2:0] MODE_PDOWN = 3'h2;
  localparam logic [2:0] MODE_PSAVE = 3'h3;
  localparam logic [2:0] MODE_STBY  = 3'h6;

  // register byte addresses
  localparam logic [7:0] ADR_SLEEP = 8'h00;
  localparam logic [7:0] ADR_MCU   = 8'h04;
  localparam logic [7:0] ADR_PCG   = 8'h08;
  localparam logic [7:0] ADR_STAT  = 8'h0C;

  // field positions
  localparam int SLP_ARM_BIT = 0;
  localparam int SLP_SEL_LSB = 1;
  localparam int SLP_SEL_MSB = 3;
  localparam int UNLOCK_BIT  = 5;
  localparam int BROWNOUT_SLEEP_OFF_BIT    = 6;
  localparam int PCG_W       = 5;
  localparam int ST_ASLEEP   = 0;
  localparam int ST_BODOFF   = 1;
  localparam int ST_WAKING   = 2;
  localparam int ST_HALTED   = 3;
  localparam int ST_MODE_LSB = 4;
  localparam int ST_MODE_MSB = 6;

  // reset values
  localparam logic [2:0]       SEL_RST = 3'h0;
  localparam logic [PCG_W-1:0] PCG_RST = 5'h00;
  localparam logic [31:0]      DAT_ZERO = 32'h0000_0000;

  typedef enum logic [3:0] {
    ST_RUN   = 4'h1,
    ST_SLEEP = 4'h2,
    ST_WAKE  = 4'h4,
    ST_HALT  = 4'h8
  } smpm_state_e;

  // clock domain and oscillator enables
  typedef struct packed {
    logic cpu;
    logic flash;
    logic io;
    logic adc;
    logic asy;
    logic osc;
    logic aux;
  } smpm_clk_s;

  localparam smpm_clk_s CLK_ALL_ON = 7'h7F;

  // wake sources, all active high levels
  typedef struct packed {
    logic any_irq;
    logic adc_done;
    logic lcd_irq;
    logic serial_start;
    logic ext_irq_zero_level;
    logic pin_change;
    logic spm_ready;
    logic t2_ovf;
    logic t2_cmp;
  } smpm_wake_s;

  // peripheral and fuse state seen by the manager
  typedef struct packed {
    logic       adc_enable;
    logic       comparator_off;
    logic       comp_uses_ref;
    logic       lcd_en;
    logic       lcd_async;
    logic       t2_en;
    logic       t2_async;
    logic [1:0] timer2_irq_mask;
    logic       global_irq_en;
    logic       brownout_threshold_fuse;
    logic       ext_xtal;
    logic [1:0] clock_select_fuse;
  } smpm_periph_s;
endpackage : smpm_pkg

/* hdl/smpm_top.sv */
// sleep mode power manager: sleep entry, clock gates, wake timing
// assumes synchronous inputs, a wishbone master, one-cycle sleep pulse
`timescale 1ns/1ps
module smpm_top #(
  parameter smpm_pkg::smpm_cnt_t BOD_WAKE_CYC = smpm_pkg::smpm_cnt_t'(
                                     smpm_pkg::BOD_WAKE_CYC_DFLT),
  parameter smpm_pkg::smpm_cnt_t RESTART_BASE = smpm_pkg::RESTART_BASE_DFLT
) (
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  input  wire logic                  wb_cyc_i,
  input  wire logic                  wb_stb_i,
  input  wire logic                  wb_we_i,
  input  wire logic [7:0]            wb_adr_i,
  input  wire logic [3:0]            wb_sel_i,
  input  wire logic [31:0]           wb_dat_i,
  output logic      [31:0]           wb_dat_o,
  output logic                       wb_ack_o,
  input  wire logic                  sleep_instr_i,
  input  wire smpm_pkg::smpm_wake_s  wake_i,
  input  wire smpm_pkg::smpm_periph_s periph_i,
  output smpm_pkg::smpm_clk_s        clk_en_o,
  output logic [smpm_pkg::PCG_W-1:0] periph_clk_en_o,
  output logic                       brownout_en_o,
  output logic                       comparator_en_o,
  output logic                       vref_en_o,
  output logic                       adc_start_o,
  output logic                       adc_extended_o
);
  import smpm_pkg::*;

  smpm_state_e      state_reg;
  smpm_cnt_t        cnt_reg;
  logic [2:0]       mode_reg;
  logic [2:0]       sel_reg;
  logic             arm_reg;
  logic [PCG_W-1:0] pcg_reg;
  smpm_seq_t        unlock_reg;
  smpm_seq_t        brownout_sleep_off_reg;
  logic             bod_off_reg;
  logic             adc_en_d_reg;
  logic             ack_reg;
  logic             wr_fire;
  logic             brownout_sleep_off_act;
  logic             sleep_go;
  logic             wake;
  logic             t2_wake;
  logic             brownout_sleep_off_set;
  logic             asy_used;
  logic             syn_used;
  smpm_cnt_t        dly_next;
  // sleep select code is usable for this clock option
  function automatic logic mode_ok(input logic [2:0] m, input logic xtal);
    mode_ok = (m == MODE_IDLE) || (m == MODE_ADCNR) || (m == MODE_PDOWN) ||
              (m == MODE_PSAVE) || ((m == MODE_STBY) && xtal);
  endfunction : mode_ok
  // modes in which the detector may be switched off
  function automatic logic deep(input logic [2:0] m);
    deep = (m == MODE_PDOWN) || (m == MODE_PSAVE) || (m == MODE_STBY);
  endfunction : deep
  // restart period picked by the clock select fuse
  function automatic smpm_cnt_t restart_cyc(input logic [1:0] f);
    restart_cyc = smpm_cnt_t'(RESTART_BASE << f);
  endfunction : restart_cyc
  // bus strobe decode: write lands on the edge that samples ack
  assign wr_fire = wb_cyc_i && wb_stb_i && wb_we_i && ack_reg && wb_sel_i[0];
  assign brownout_sleep_off_act = (brownout_sleep_off_reg != SEQ_ZERO) && (brownout_sleep_off_reg <= BROWNOUT_SLEEP_OFF_ACT_LAST);
  assign sleep_go = (state_reg == ST_RUN) && sleep_instr_i && arm_reg &&
                    mode_ok(sel_reg, periph_i.ext_xtal);
  assign brownout_sleep_off_set = wr_fire && (wb_adr_i == ADR_MCU) &&
                    wb_dat_i[BROWNOUT_SLEEP_OFF_BIT] && !wb_dat_i[UNLOCK_BIT] &&
                    (unlock_reg != SEQ_ZERO) && (brownout_sleep_off_reg == SEQ_ZERO);
  assign asy_used = (periph_i.lcd_en && periph_i.lcd_async) ||
                    (periph_i.t2_en && periph_i.t2_async);
  assign syn_used = (periph_i.lcd_en && !periph_i.lcd_async) ||
                    (periph_i.t2_en && !periph_i.t2_async);
  // timer 2 wake needs its mask bit and the global enable
  assign t2_wake = periph_i.global_irq_en &&
                   ((wake_i.t2_ovf && periph_i.timer2_irq_mask[0]) ||
                    (wake_i.t2_cmp && periph_i.timer2_irq_mask[1]));
  // wake source selection per sleep mode
  always_comb begin
    wake = 1'b0;
    case (mode_reg)
      MODE_IDLE:  wake = wake_i.any_irq || wake_i.serial_start ||
                         wake_i.ext_irq_zero_level || wake_i.pin_change;
      MODE_ADCNR: wake = wake_i.adc_done || wake_i.lcd_irq ||
                         wake_i.serial_start || t2_wake ||
                         wake_i.spm_ready || wake_i.ext_irq_zero_level ||
                         wake_i.pin_change;
      MODE_PSAVE: wake = wake_i.serial_start || wake_i.ext_irq_zero_level ||
                         wake_i.pin_change || t2_wake ||
                         wake_i.lcd_irq;
      MODE_PDOWN,
      MODE_STBY:  wake = wake_i.serial_start || wake_i.ext_irq_zero_level ||
                         wake_i.pin_change;
      default:    wake = 1'b0;
    endcase
  end
  // start-up delay chosen when the wake condition arrives
  always_comb begin
    dly_next = CNT_ONE;
    case (mode_reg)
      MODE_PDOWN,
      MODE_PSAVE: dly_next = restart_cyc(periph_i.clock_select_fuse);
      MODE_STBY:  dly_next = STBY_CYC;
      default:    dly_next = CNT_ONE;
    endcase
    if (bod_off_reg && (dly_next < BOD_WAKE_CYC)) begin
      dly_next = BOD_WAKE_CYC;
    end
  end
  // sleep sequencer: run, sleep, restart wait, halt
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= ST_RUN;
      cnt_reg   <= CNT_ONE;
      mode_reg  <= SEL_RST;
    end else begin
      case (state_reg)
        ST_RUN: begin
          if (sleep_go) begin
            state_reg <= ST_SLEEP;
            mode_reg  <= sel_reg;
          end
        end
        ST_SLEEP: begin
          if (wake) begin
            state_reg <= ST_WAKE;
            cnt_reg   <= dly_next;
          end
        end
        ST_WAKE: begin
          if (cnt_reg <= CNT_ONE) begin
            state_reg <= ST_HALT;
            cnt_reg   <= HALT_CYC;
          end else begin
            cnt_reg <= cnt_reg - CNT_ONE;
          end
        end
        ST_HALT: begin
          if (cnt_reg <= CNT_ONE) begin
            state_reg <= ST_RUN;
          end else begin
            cnt_reg <= cnt_reg - CNT_ONE;
          end
        end
        default: state_reg <= ST_RUN;
      endcase
    end
  end
  // sleep control register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sel_reg <= SEL_RST;
      arm_reg <= 1'b0;
    end else if (wr_fire && (wb_adr_i == ADR_SLEEP)) begin
      sel_reg <= wb_dat_i[SLP_SEL_MSB:SLP_SEL_LSB];
      arm_reg <= wb_dat_i[SLP_ARM_BIT];
    end
  end
  // brown-out sleep-off unlock window and self-clearing sequence
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      unlock_reg <= SEQ_ZERO;
      brownout_sleep_off_reg   <= SEQ_ZERO;
    end else begin
      if (wr_fire && (wb_adr_i == ADR_MCU) && wb_dat_i[BROWNOUT_SLEEP_OFF_BIT] &&
          wb_dat_i[UNLOCK_BIT]) begin
        unlock_reg <= UNLOCK_CYC;
      end else if (unlock_reg != SEQ_ZERO) begin
        unlock_reg <= unlock_reg - SEQ_ONE;
      end
      if (brownout_sleep_off_set) begin
        brownout_sleep_off_reg <= BROWNOUT_SLEEP_OFF_TOTAL;
      end else if (brownout_sleep_off_reg != SEQ_ZERO) begin
        brownout_sleep_off_reg <= brownout_sleep_off_reg - SEQ_ONE;
      end
    end
  end
  // detector switched off for the sleep period
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bod_off_reg <= 1'b0;
    end else if (sleep_go && brownout_sleep_off_act && deep(sel_reg) &&
                 periph_i.brownout_threshold_fuse) begin
      bod_off_reg <= 1'b1;
    end else if ((state_reg == ST_SLEEP) && wake) begin
      bod_off_reg <= 1'b0;
    end
  end
  // peripheral clock gate register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pcg_reg <= PCG_RST;
    end else if (wr_fire && (wb_adr_i == ADR_PCG)) begin
      pcg_reg <= wb_dat_i[PCG_W-1:0];
    end
  end
  // clock domain enables per state and mode
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clk_en_o <= CLK_ALL_ON;
    end else begin
      clk_en_o <= CLK_ALL_ON;
      if (state_reg == ST_HALT) begin
        clk_en_o.cpu   <= 1'b0;
        clk_en_o.flash <= 1'b0;
      end else if (state_reg != ST_RUN) begin
        clk_en_o.cpu   <= 1'b0;
        clk_en_o.flash <= 1'b0;
        case (mode_reg)
          MODE_IDLE: ;
          MODE_ADCNR: begin
            clk_en_o.io  <= 1'b0;
            clk_en_o.aux <= 1'b0;
            clk_en_o.asy <= asy_used;
          end
          MODE_PSAVE: begin
            clk_en_o.io  <= 1'b0;
            clk_en_o.adc <= 1'b0;
            clk_en_o.asy <= asy_used;
            clk_en_o.osc <= syn_used || (state_reg == ST_WAKE);
            clk_en_o.aux <= syn_used;
          end
          MODE_STBY: begin
            clk_en_o.io  <= 1'b0;
            clk_en_o.adc <= 1'b0;
            clk_en_o.asy <= 1'b0;
            clk_en_o.aux <= 1'b0;
          end
          default: begin
            clk_en_o.io  <= 1'b0;
            clk_en_o.adc <= 1'b0;
            clk_en_o.asy <= 1'b0;
            clk_en_o.aux <= 1'b0;
            clk_en_o.osc <= (state_reg == ST_WAKE);
          end
        endcase
      end
    end
  end
  // registered peripheral clocks follow the gate bits
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      periph_clk_en_o <= ~PCG_RST;
    end else begin
      periph_clk_en_o <= ~pcg_reg;
    end
  end
  // detector, comparator and reference enables
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      brownout_en_o   <= 1'b0;
      comparator_en_o <= 1'b0;
      vref_en_o       <= 1'b0;
    end else begin
      brownout_en_o   <= periph_i.brownout_threshold_fuse && !bod_off_reg;
      comparator_en_o <= !periph_i.comparator_off &&
                         ((state_reg == ST_RUN) || !deep(mode_reg));
      vref_en_o <= (periph_i.brownout_threshold_fuse && !bod_off_reg) ||
                   (!periph_i.comparator_off && periph_i.comp_uses_ref) ||
                   periph_i.adc_enable;
    end
  end
  // adc auto start and extended first conversion after re-enable
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      adc_start_o    <= 1'b0;
      adc_extended_o <= 1'b0;
      adc_en_d_reg   <= 1'b0;
    end else begin
      adc_en_d_reg <= periph_i.adc_enable;
      adc_start_o  <= sleep_go && periph_i.adc_enable &&
                      ((sel_reg == MODE_IDLE) ||
                       (sel_reg == MODE_ADCNR));
      if (periph_i.adc_enable && !adc_en_d_reg) begin
        adc_extended_o <= 1'b1;
      end else if (wake_i.adc_done) begin
        adc_extended_o <= 1'b0;
      end
    end
  end
  // wishbone slave: one wait state, unmapped reads return zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg  <= 1'b0;
      wb_ack_o <= 1'b0;
      wb_dat_o <= DAT_ZERO;
    end else begin
      ack_reg  <= wb_cyc_i && wb_stb_i && !ack_reg;
      wb_ack_o <= wb_cyc_i && wb_stb_i && !ack_reg;
      wb_dat_o <= DAT_ZERO;
      case (wb_adr_i)
        ADR_SLEEP: begin
          wb_dat_o[SLP_SEL_MSB:SLP_SEL_LSB] <= sel_reg;
          wb_dat_o[SLP_ARM_BIT]             <= arm_reg;
        end
        ADR_MCU: begin
          wb_dat_o[BROWNOUT_SLEEP_OFF_BIT]   <= (brownout_sleep_off_reg != SEQ_ZERO);
          wb_dat_o[UNLOCK_BIT] <= (unlock_reg != SEQ_ZERO);
        end
        ADR_PCG:  wb_dat_o[PCG_W-1:0] <= pcg_reg;
        ADR_STAT: begin
          wb_dat_o[ST_ASLEEP] <= (state_reg == ST_SLEEP);
          wb_dat_o[ST_BODOFF] <= bod_off_reg;
          wb_dat_o[ST_WAKING] <= (state_reg == ST_WAKE);
          wb_dat_o[ST_HALTED] <= (state_reg == ST_HALT);
          wb_dat_o[ST_MODE_MSB:ST_MODE_LSB] <= mode_reg;
        end
        default: ;
      endcase
    end
  end

  // checks on the block's own behaviour
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_brownout_sleep_off_wait;
    !brownout_sleep_off_act [*3];
  endsequence
  sequence s_brownout_sleep_off_live;
    brownout_sleep_off_act [*3];
  endsequence
  a_bod_off_entry: assert property (sleep_go && brownout_sleep_off_act && deep(sel_reg) &&
    periph_i.brownout_threshold_fuse |=> bod_off_reg ##1 !brownout_en_o)
    else $error("detector not switched off at sleep entry");
  a_bod_back_on: assert property ((state_reg == ST_SLEEP) && wake |=> ##1
    (brownout_en_o == periph_i.brownout_threshold_fuse))
    else $error("detector not re-enabled at wake");
  a_bod_wake_len: assert property ((state_reg == ST_SLEEP) && wake &&
    bod_off_reg |=> (state_reg == ST_WAKE) && (cnt_reg >= BOD_WAKE_CYC))
    else $error("wake delay not stretched after detector off");
  a_brownout_sleep_off_timing: assert property (brownout_sleep_off_set |=> s_brownout_sleep_off_wait ##1 s_brownout_sleep_off_live
    ##1 (brownout_sleep_off_reg == SEQ_ZERO))
    else $error("sleep-off active window wrong");
  a_brownout_sleep_off_locked: assert property (wr_fire && (wb_adr_i == ADR_MCU) &&
    (unlock_reg == SEQ_ZERO) && (brownout_sleep_off_reg == SEQ_ZERO) |=>
    (brownout_sleep_off_reg == SEQ_ZERO))
    else $error("sleep-off set without unlock");
  a_halt_four: assert property ($rose(state_reg == ST_HALT) |->
    (state_reg == ST_HALT) [*4] ##1 (state_reg == ST_RUN))
    else $error("cpu halt not four cycles");
  a_idle_gate: assert property ((state_reg == ST_SLEEP) &&
    ($past(state_reg) == ST_SLEEP) && (mode_reg == MODE_IDLE) |->
    !clk_en_o.cpu && !clk_en_o.flash && clk_en_o.io && clk_en_o.osc)
    else $error("idle gating wrong");
  a_pdown_gate: assert property ((state_reg == ST_SLEEP) &&
    ($past(state_reg) == ST_SLEEP) && (mode_reg == MODE_PDOWN) |->
    !clk_en_o.io && !clk_en_o.osc && !clk_en_o.asy && !clk_en_o.cpu)
    else $error("power-down gating wrong");
  a_adc_start: assert property (sleep_go && periph_i.adc_enable &&
    (sel_reg == MODE_ADCNR) |=> adc_start_o)
    else $error("adc not started on sleep entry");
  a_stby_wake: assert property ((state_reg == ST_SLEEP) && wake &&
    (mode_reg == MODE_STBY) && !bod_off_reg |=> (state_reg == ST_WAKE) [*6]
    ##1 (state_reg == ST_HALT))
    else $error("standby wake not six cycles");
  a_pcg_apply: assert property (wr_fire && (wb_adr_i == ADR_PCG) |=> ##1
    (periph_clk_en_o == ~$past(wb_dat_i[PCG_W-1:0], 2)))
    else $error("gate write not applied");
  a_bad_mode: assert property ((state_reg == ST_RUN) && sleep_instr_i &&
    !mode_ok(sel_reg, periph_i.ext_xtal) |=> (state_reg == ST_RUN))
    else $error("sleep entered with reserved code");
endmodule : smpm_top

/* tb/smpm_cpu_model.sv */
// cpu side model: issues the sleep instruction, holds wake levels
// assumes one system clock and the manager's clock enables
`timescale 1ns/1ps
module smpm_cpu_model (
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  input  wire logic                 exec_i,
  input  wire smpm_pkg::smpm_wake_s wake_req_i,
  input  wire smpm_pkg::smpm_clk_s  clk_en_i,
  output logic                      sleep_instr_o,
  output smpm_pkg::smpm_wake_s      wake_o
);
  import smpm_pkg::*;
  logic cpu_q;
  // sleep executes only while the cpu is clocked, one cycle long
  always_ff @(posedge clk_i) begin
    sleep_instr_o <= exec_i && clk_en_i.cpu && !sleep_instr_o;
  end
  // previous cpu clock enable, to see the cpu resume
  always_ff @(posedge clk_i) begin
    cpu_q <= clk_en_i.cpu;
  end
  // a wake level stays until the cpu runs again
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wake_o <= '0;
    end else if (wake_req_i != '0) begin
      wake_o <= wake_o | wake_req_i;
    end else if (clk_en_i.cpu && !cpu_q) begin
      wake_o <= '0;
    end
  end
endmodule : smpm_cpu_model

/* tb/test_sleep_mode_power_manager.sv */
// self-checking bench of the sleep mode power manager
// assumes shortened wake counts: detector wake 20, restart base 8
`timescale 1ns/1ps
module test_sleep_mode_power_manager;
  import smpm_pkg::*;
  logic         clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, we = 1'b0;
  logic         exec = 1'b0, ack, sli, brownout_detector, cmp, vref, ast, aext;
  logic [7:0]   adr = 8'h00;
  logic [31:0]  dat = 32'h0, rdat, q;
  logic [4:0]   pce;
  smpm_wake_s   wreq = '0, wk_s;
  smpm_periph_s per = '0;
  smpm_clk_s    ce;
  int           n_errors = 0, checked = 0, n_adc = 0, n;
  // system clock, 200 MHz
  always #2.5 clk_i = ~clk_i;
  smpm_top #(.BOD_WAKE_CYC(16'h0014), .RESTART_BASE(16'h0008)) DUT (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .sleep_instr_i(sli), .wake_i(wk_s),
    .periph_i(per), .clk_en_o(ce), .periph_clk_en_o(pce),
    .brownout_en_o(brownout_detector), .comparator_en_o(cmp), .vref_en_o(vref),
    .adc_start_o(ast), .adc_extended_o(aext));
  smpm_cpu_model cpu (.clk_i(clk_i), .rst_i(rst_i), .exec_i(exec),
    .wake_req_i(wreq), .clk_en_i(ce), .sleep_instr_o(sli), .wake_o(wk_s));
  // counts conversion start pulses
  always @(posedge clk_i) if (ast === 1'b1) n_adc++;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // one classic wishbone cycle, returns at the ack edge
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1; we <= w; adr <= a; dat <= d;
    do @(posedge clk_i); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0; we <= 1'b0;
  endtask : wb
  // cpu executes sleep, then the mode settles
  task automatic go;
    @(posedge clk_i) exec <= 1'b1;
    @(posedge clk_i) exec <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask : go
  // raise a wake source, count cycles until the cpu clock runs
  task automatic wake(input smpm_wake_s w, input int lim, output int c);
    @(posedge clk_i) wreq <= w;
    @(posedge clk_i) wreq <= '0;
    c = 1;
    while (ce.cpu !== 1'b1 && c < lim) begin
      @(posedge clk_i);
      c++;
    end
  endtask : wake
  task automatic t_reset;
    chk(pce, 5'h1F);
    chk(ce, CLK_ALL_ON);
    wb(1'b0, ADR_MCU, DAT_ZERO); chk(q, DAT_ZERO);
    wb(1'b1, 8'h10, 32'hFF); wb(1'b0, 8'h10, DAT_ZERO); chk(q, DAT_ZERO);
    $display("reset test done");
  endtask : t_reset
  task automatic t_idle;
    wb(1'b1, ADR_SLEEP, 32'h1); go;
    chk({ce.cpu, ce.flash, ce.io, ce.adc}, 4'h3);
    chk(n_adc, 1);
    wake('{any_irq: 1'b1, default: 1'b0}, 50, n);
    chk(n >= 5 && n <= 9, 1'b1);
    wb(1'b1, ADR_SLEEP, 32'h3); go;
    chk({ce.cpu, ce.io, ce.adc}, 3'h1);
    chk(n_adc, 2);
    wake('{spm_ready: 1'b1, default: 1'b0}, 50, n);
    chk(n <= 9, 1'b1);
    $display("idle and noise test done");
  endtask : t_idle
  task automatic t_pdown;
    wb(1'b1, ADR_SLEEP, 32'h5);
    wb(1'b1, ADR_MCU, 32'h60);
    wb(1'b1, ADR_MCU, 32'h40);
    // sleep-off is live only from the fourth cycle after it is set
    @(posedge clk_i);
    go;
    chk(brownout_detector, 1'b0);
    chk({ce.osc, cmp}, 2'h0);
    wake('{t2_ovf: 1'b1, default: 1'b0}, 30, n);
    chk(ce.cpu, 1'b0);
    wake('{pin_change: 1'b1, default: 1'b0}, 100, n);
    chk(n >= 24 && n <= 30, 1'b1);
    chk(brownout_detector, 1'b1);
    $display("power-down test done");
  endtask : t_pdown
  task automatic t_modes;
    wb(1'b1, ADR_SLEEP, 32'h9); go;
    chk(ce.cpu, 1'b1);
    per.ext_xtal <= 1'b1;
    wb(1'b1, ADR_SLEEP, 32'hD); go;
    chk({ce.cpu, ce.osc}, 2'h1);
    wake('{ext_irq_zero_level: 1'b1, default: 1'b0}, 50, n);
    chk(n >= 10 && n <= 14, 1'b1);
    $display("reserved and standby test done");
  endtask : t_modes
  task automatic t_gate;
    // a finished conversion ends the extended flag
    wake('{adc_done: 1'b1, default: 1'b0}, 4, n);
    repeat (2) @(posedge clk_i);
    chk(aext, 1'b0);
    per.adc_enable <= 1'b0;
    wb(1'b1, ADR_PCG, 32'h5);
    @(posedge clk_i) #1 chk(pce, 5'h1A);
    wb(1'b0, ADR_PCG, DAT_ZERO); chk(q, 32'h5);
    wb(1'b1, ADR_PCG, DAT_ZERO);
    @(posedge clk_i) #1 chk(pce, 5'h1F);
    // no user of the reference left, then the converter returns
    @(posedge clk_i);
    per.brownout_threshold_fuse <= 1'b0;
    per.comparator_off <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk({brownout_detector, cmp, vref}, 3'h0);
    per.adc_enable <= 1'b1;
    repeat (2) @(posedge clk_i);
    chk({vref, aext}, 2'h3);
    $display("gate test done");
  endtask : t_gate
  task automatic conclude;
    $display("checked=%0d n_errors=%0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : conclude
  // main sequence
  initial begin
    per.adc_enable <= 1'b1;
    per.brownout_threshold_fuse <= 1'b1;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    t_reset;
    t_idle;
    t_pdown;
    t_modes;
    t_gate;
    conclude;
  end
  // watchdog: the tests need well under 2000 cycles
  initial begin
    #(20000 * 5);
    n_errors++;
    conclude;
  end
endmodule : test_sleep_mode_power_manager
